//--- hw/dsrf_top.sv
// Dual-state general-purpose, saved-status and FP/SIMD register file
//
// Overview of operation
// - Thirty-one 64-bit general registers, fully usable in the 64-bit state.
// - Compatibility state sees only low 32 bits; high halves stay hidden.
// - Banked compatibility registers live in low halves of spare 64-bit registers.
// - Saved-status and hyp return address sit outside the general space.
// - Supervisor/hyp saved status and return address alias first/second level ones.
// - Abort, undefined, irq, fiq saved status kept while 64-bit runs.
// - In 64-bit state saved status reachable only from higher privilege.
// - Exception from 32-bit into 64-bit zeroes return-address top half.
// - Compatibility state holds Q, four greater-or-equal, eight cond-block, J, T, E, mode.
// - Separate bank of thirty-two 128-bit FP/SIMD registers.
// - Scalar access uses low bits; high bits ignored on read, zeroed on write.
// - Low 64 bits form double view, low 32 bits single view, same number.
// - Low 16 bits half view, low 8 bits byte view for SIMD only.
// - Vector shapes 8B,4H,2S,1D over 64 bits; 16B,8H,4S,2D over 128.
// - Compatibility FP/SIMD registers live inside the 64-bit FP/SIMD bank.
// - FP/SIMD registers 16 to 31 unreachable and unchanged in compatibility state.
// - On return to 64-bit, hidden registers keep their earlier contents.
`default_nettype none

module dsrf_top
    import dsrf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic exec_64,
    input wire logic [1:0] cur_level,
    input wire logic sat_event,
    input wire logic gpr_rd_en,
    input wire logic [4:0] gpr_rd_idx,
    output logic [63:0] gpr_rd_data,
    input wire logic gpr_wr_en,
    input wire logic [4:0] gpr_wr_idx,
    input wire logic [63:0] gpr_wr_data,
    input wire logic fp_rd_en,
    input wire logic [4:0] fp_rd_idx,
    input wire dsrf_size_t fp_rd_size,
    input wire logic fp_rd_simd,
    input wire dsrf_shape_t fp_rd_shape,
    input wire logic [3:0] fp_rd_lane,
    output logic [127:0] fp_rd_data,
    output logic [63:0] fp_lane_data,
    input wire logic fp_wr_en,
    input wire logic [4:0] fp_wr_idx,
    input wire dsrf_size_t fp_wr_size,
    input wire logic fp_wr_simd,
    input wire logic [127:0] fp_wr_data,
    input wire logic [7:0] sys_addr,
    input wire logic [31:0] sys_wdata,
    input wire logic sys_wr,
    input wire logic sys_rd,
    output logic [31:0] sys_rdata,
    output logic sys_denied,
    input wire logic exc_take,
    input wire logic [1:0] exc_target,
    input wire logic [63:0] exc_ret_addr,
    output logic [31:0] processor_state
);

    typedef struct packed {
        logic [DSRF_GPR_NUM-1:0][DSRF_GPR_W-1:0] gpr;
        logic [DSRF_FP_NUM-1:0][DSRF_FP_W-1:0] fp;
        logic [5:0][31:0] saved_status_reg;
        logic [63:0] exception_return_addr_os;
        logic [63:0] exception_return_addr_hyp;
        logic [31:0] current_status_reg;
        logic [63:0] gpr_rdata;
        logic [127:0] fp_rdata;
        logic [63:0] lane_data;
        logic [31:0] sys_rdata;
        logic denied;
    } dsrf_state_t;

    dsrf_state_t st_r;
    dsrf_state_t st_nxt;
    logic [63:0] lane_elem;

    ////////////////////////////////////////////////////////////////////////////
    // Index translation and lane extraction

    dsrf_map_if rmap ();
    dsrf_map_if wmap ();

    // Mode field of the status register steers banking
    assign rmap.exec_64 = exec_64;
    assign rmap.mode = st_r.current_status_reg[4:0];
    assign rmap.arch_idx = gpr_rd_idx;
    assign wmap.exec_64 = exec_64;
    assign wmap.mode = st_r.current_status_reg[4:0];
    assign wmap.arch_idx = gpr_wr_idx;

    dsrf_bank_map u_rmap (.m(rmap.map));
    dsrf_bank_map u_wmap (.m(wmap.map));

    dsrf_lane u_lane (
        .vec(st_r.fp[fp_rd_idx]),
        .shape(fp_rd_shape),
        .lane(fp_rd_lane),
        .elem(lane_elem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [127:0] size_mask(input dsrf_size_t sz);
        case (sz)
            DSRF_SZ_B: size_mask = {120'h0, 8'hFF};
            DSRF_SZ_H: size_mask = {112'h0, 16'hFFFF};
            DSRF_SZ_S: size_mask = {96'h0, 32'hFFFFFFFF};
            DSRF_SZ_D: size_mask = {64'h0, 64'hFFFFFFFFFFFFFFFF};
            default: size_mask = '1;
        endcase
    endfunction

    // High half of the bank is hidden in compatibility state; byte view is SIMD only
    function automatic logic fp_ok(input logic e64, input logic [4:0] idx,
                                   input dsrf_size_t sz, input logic simd);
        fp_ok = (e64 || !idx[4]) && (sz != DSRF_SZ_B || simd);
    endfunction

    // Privilege check for the system register port
    function automatic logic sys_ok(input logic e64, input logic [1:0] lvl,
                                    input logic [4:0] mode, input logic [7:0] addr);
        if (!e64)
        begin
            sys_ok = (mode != DSRF_MODE_USR);
        end
        else
        begin
            case (addr)
                DSRF_OFS_CUR, DSRF_OFS_SPS_OS, DSRF_OFS_ELR1_LO, DSRF_OFS_ELR1_HI:
                    sys_ok = (lvl >= 2'd1);
                default: sys_ok = (lvl >= 2'd2);
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.denied = 1'b0;
        st_nxt.gpr_rdata = '0;
        st_nxt.fp_rdata = '0;
        st_nxt.lane_data = '0;
        st_nxt.sys_rdata = '0;

        // General registers
        if (gpr_rd_en && rmap.valid)
        begin
            if (exec_64)
                st_nxt.gpr_rdata = st_r.gpr[rmap.phys_idx];
            else
                st_nxt.gpr_rdata = {32'h0, st_r.gpr[rmap.phys_idx][31:0]};
        end
        if (gpr_wr_en && wmap.valid)
        begin
            if (exec_64)
                st_nxt.gpr[wmap.phys_idx] = gpr_wr_data;
            else
                st_nxt.gpr[wmap.phys_idx][31:0] = gpr_wr_data[31:0];
        end

        // FP/SIMD bank shared by both states
        if (fp_rd_en && fp_ok(exec_64, fp_rd_idx, fp_rd_size, fp_rd_simd))
        begin
            st_nxt.fp_rdata = st_r.fp[fp_rd_idx] & size_mask(fp_rd_size);
            st_nxt.lane_data = lane_elem;
        end
        if (fp_wr_en && fp_ok(exec_64, fp_wr_idx, fp_wr_size, fp_wr_simd))
        begin
            st_nxt.fp[fp_wr_idx] = fp_wr_data & size_mask(fp_wr_size);
        end

        // System register port; hidden saved status only changes here
        if (sys_rd || sys_wr)
        begin
            if (!sys_ok(exec_64, cur_level, st_r.current_status_reg[4:0], sys_addr))
            begin
                st_nxt.denied = 1'b1;
            end
            else if (sys_rd)
            begin
                case (sys_addr)
                    DSRF_OFS_CUR: st_nxt.sys_rdata = st_r.current_status_reg;
                    DSRF_OFS_SPS_FIQ: st_nxt.sys_rdata = st_r.saved_status_reg[DSRF_SPS_FIQ];
                    DSRF_OFS_SPS_IRQ: st_nxt.sys_rdata = st_r.saved_status_reg[DSRF_SPS_IRQ];
                    DSRF_OFS_SPS_ABT: st_nxt.sys_rdata = st_r.saved_status_reg[DSRF_SPS_ABT];
                    DSRF_OFS_SPS_UND: st_nxt.sys_rdata = st_r.saved_status_reg[DSRF_SPS_UND];
                    DSRF_OFS_SPS_OS: st_nxt.sys_rdata = st_r.saved_status_reg[DSRF_SPS_OS];
                    DSRF_OFS_SPS_HYP: st_nxt.sys_rdata = st_r.saved_status_reg[DSRF_SPS_HYP];
                    DSRF_OFS_ELR1_LO: st_nxt.sys_rdata = st_r.exception_return_addr_os[31:0];
                    DSRF_OFS_ELR1_HI:
                        if (exec_64) st_nxt.sys_rdata = st_r.exception_return_addr_os[63:32];
                    DSRF_OFS_ELR2_LO: st_nxt.sys_rdata = st_r.exception_return_addr_hyp[31:0];
                    DSRF_OFS_ELR2_HI:
                        if (exec_64) st_nxt.sys_rdata = st_r.exception_return_addr_hyp[63:32];
                    default: st_nxt.sys_rdata = '0;
                endcase
            end
            else
            begin
                case (sys_addr)
                    DSRF_OFS_CUR: st_nxt.current_status_reg = sys_wdata;
                    DSRF_OFS_SPS_FIQ: st_nxt.saved_status_reg[DSRF_SPS_FIQ] = sys_wdata;
                    DSRF_OFS_SPS_IRQ: st_nxt.saved_status_reg[DSRF_SPS_IRQ] = sys_wdata;
                    DSRF_OFS_SPS_ABT: st_nxt.saved_status_reg[DSRF_SPS_ABT] = sys_wdata;
                    DSRF_OFS_SPS_UND: st_nxt.saved_status_reg[DSRF_SPS_UND] = sys_wdata;
                    DSRF_OFS_SPS_OS: st_nxt.saved_status_reg[DSRF_SPS_OS] = sys_wdata;
                    DSRF_OFS_SPS_HYP: st_nxt.saved_status_reg[DSRF_SPS_HYP] = sys_wdata;
                    DSRF_OFS_ELR1_LO: st_nxt.exception_return_addr_os[31:0] = sys_wdata;
                    DSRF_OFS_ELR1_HI:
                        if (exec_64) st_nxt.exception_return_addr_os[63:32] = sys_wdata;
                    DSRF_OFS_ELR2_LO: st_nxt.exception_return_addr_hyp[31:0] = sys_wdata;
                    DSRF_OFS_ELR2_HI:
                        if (exec_64) st_nxt.exception_return_addr_hyp[63:32] = sys_wdata;
                    default: st_nxt.denied = 1'b0;
                endcase
            end
        end

        // Saturation is sticky: a hardware set beats a software clear
        if (sat_event)
            st_nxt.current_status_reg[DSRF_CUR_Q] = 1'b1;

        // Exception entry overrides a port write in the same cycle
        if (exc_take && exc_target == 2'd1)
        begin
            st_nxt.saved_status_reg[DSRF_SPS_OS] = st_r.current_status_reg;
            st_nxt.exception_return_addr_os = exec_64 ? exc_ret_addr
                                            : {32'h0, exc_ret_addr[31:0]};
        end
        else if (exc_take && exc_target == 2'd2)
        begin
            st_nxt.saved_status_reg[DSRF_SPS_HYP] = st_r.current_status_reg;
            st_nxt.exception_return_addr_hyp = exec_64 ? exc_ret_addr
                                             : {32'h0, exc_ret_addr[31:0]};
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.current_status_reg <= DSRF_CUR_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign gpr_rd_data = st_r.gpr_rdata;
    assign fp_rd_data = st_r.fp_rdata;
    assign fp_lane_data = st_r.lane_data;
    assign sys_rdata = st_r.sys_rdata;
    assign sys_denied = st_r.denied;
    assign processor_state = st_r.current_status_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [2047:0] fp_hi;
    logic [127:0] sps_hidden;
    assign fp_hi = st_r.fp[31:16];
    assign sps_hidden = st_r.saved_status_reg[3:0];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_GPR64_WR_RD: assert property (
        (exec_64 && gpr_wr_en && gpr_wr_idx != DSRF_ZERO_IDX && !exc_take)
        ##1 (exec_64 && gpr_rd_en && gpr_rd_idx == $past(gpr_wr_idx) && !gpr_wr_en)
        |=> gpr_rd_data == $past(gpr_wr_data, 2))
        else $error("64-bit general register write not read back");
    AST_GPR32_HIGH: assert property (
        !exec_64 && gpr_rd_en |=> gpr_rd_data[63:32] == 32'h0)
        else $error("high half visible in compatibility state");
    AST_FIQ_SP_MAP: assert property (
        !exec_64 && st_r.current_status_reg[4:0] == DSRF_MODE_FIQ && gpr_rd_idx == 5'h0D
        |-> rmap.phys_idx == DSRF_FIQ_SP && rmap.valid)
        else $error("fast-interrupt stack pointer mapped wrongly");
    AST_SPS_KEEP: assert property (
        exec_64 && !sys_wr |=> $stable(sps_hidden))
        else $error("hidden saved status changed");
    AST_SYS_DENY: assert property (
        exec_64 && sys_rd && sys_addr == DSRF_OFS_SPS_FIQ && cur_level < 2'd2
        |=> sys_denied && sys_rdata == 32'h0)
        else $error("saved status read at too low a level");
    AST_ELR_ZERO: assert property (
        exc_take && !exec_64 && exc_target == 2'd1
        |=> st_r.exception_return_addr_os[63:32] == 32'h0
            && st_r.exception_return_addr_os[31:0] == $past(exc_ret_addr[31:0]))
        else $error("return address top half not zeroed");
    AST_Q_STICKY: assert property (
        sat_event |=> processor_state[DSRF_CUR_Q])
        else $error("saturation flag lost");
    AST_FP_SCALAR: assert property (
        fp_rd_en && fp_rd_size == DSRF_SZ_S |=> fp_rd_data[127:32] == 96'h0)
        else $error("scalar read leaked high bits");
    AST_FP_HI_LOCK: assert property (
        !exec_64 |=> $stable(fp_hi))
        else $error("upper FP bank changed in compatibility state");
    AST_LANE_4S: assert property (
        fp_rd_en && fp_rd_shape == DSRF_SH_4S |=> fp_lane_data[63:32] == 32'h0)
        else $error("word lane leaked into upper half");

    COV_FIQ_BANK: cover property (!exec_64 && gpr_wr_en && wmap.phys_idx == DSRF_FIQ_R8);
    COV_EXC_32: cover property (exc_take && !exec_64);
    COV_FP_VEC: cover property (fp_rd_en && fp_rd_shape == DSRF_SH_4S);
    COV_DENY: cover property (sys_denied);

endmodule // dsrf_top

`default_nettype wire

//--- hw/dsrf_pkg.sv
// Shared constants and types for the dual-state register file
`default_nettype none

package dsrf_pkg;

    // Architectural sizes
    localparam int DSRF_GPR_NUM = 31;
    localparam int DSRF_GPR_W = 64;
    localparam int DSRF_FP_NUM = 32;
    localparam int DSRF_FP_W = 128;
    localparam int DSRF_FP_LOW_NUM = 16;
    localparam int DSRF_SYS_AW = 8;

    // Compatibility-state mode field encodings
    localparam logic [4:0] DSRF_MODE_USR = 5'h10;
    localparam logic [4:0] DSRF_MODE_FIQ = 5'h11;
    localparam logic [4:0] DSRF_MODE_IRQ = 5'h12;
    localparam logic [4:0] DSRF_MODE_SVC = 5'h13;
    localparam logic [4:0] DSRF_MODE_ABT = 5'h17;
    localparam logic [4:0] DSRF_MODE_HYP = 5'h1A;
    localparam logic [4:0] DSRF_MODE_UND = 5'h1B;

    // Banked physical targets
    localparam logic [4:0] DSRF_FIQ_R8 = 5'h18;
    localparam logic [4:0] DSRF_FIQ_SP = 5'h1D;
    localparam logic [4:0] DSRF_FIQ_LR = 5'h1E;
    localparam logic [4:0] DSRF_IRQ_SP = 5'h11;
    localparam logic [4:0] DSRF_IRQ_LR = 5'h10;
    localparam logic [4:0] DSRF_ABT_SP = 5'h15;
    localparam logic [4:0] DSRF_ABT_LR = 5'h14;
    localparam logic [4:0] DSRF_SVC_SP = 5'h13;
    localparam logic [4:0] DSRF_SVC_LR = 5'h12;
    localparam logic [4:0] DSRF_UND_SP = 5'h17;
    localparam logic [4:0] DSRF_UND_LR = 5'h16;
    localparam logic [4:0] DSRF_HYP_SP = 5'h0F;
    localparam logic [4:0] DSRF_ZERO_IDX = 5'h1F;

    // System register port byte offsets
    localparam logic [7:0] DSRF_OFS_CUR = 8'h00;
    localparam logic [7:0] DSRF_OFS_SPS_FIQ = 8'h04;
    localparam logic [7:0] DSRF_OFS_SPS_IRQ = 8'h08;
    localparam logic [7:0] DSRF_OFS_SPS_ABT = 8'h0C;
    localparam logic [7:0] DSRF_OFS_SPS_UND = 8'h10;
    localparam logic [7:0] DSRF_OFS_SPS_OS = 8'h14;
    localparam logic [7:0] DSRF_OFS_SPS_HYP = 8'h18;
    localparam logic [7:0] DSRF_OFS_ELR1_LO = 8'h1C;
    localparam logic [7:0] DSRF_OFS_ELR1_HI = 8'h20;
    localparam logic [7:0] DSRF_OFS_ELR2_LO = 8'h24;
    localparam logic [7:0] DSRF_OFS_ELR2_HI = 8'h28;

    // Saved-status bank slots
    localparam int DSRF_SPS_FIQ = 0;
    localparam int DSRF_SPS_IRQ = 1;
    localparam int DSRF_SPS_ABT = 2;
    localparam int DSRF_SPS_UND = 3;
    localparam int DSRF_SPS_OS = 4;
    localparam int DSRF_SPS_HYP = 5;

    // Current status register field positions and reset value
    localparam int DSRF_CUR_Q = 27;
    localparam logic [31:0] DSRF_CUR_RST = 32'h000001D3;

    typedef enum logic [2:0] {
        DSRF_SZ_B = 3'b000,
        DSRF_SZ_H = 3'b001,
        DSRF_SZ_S = 3'b010,
        DSRF_SZ_D = 3'b011,
        DSRF_SZ_Q = 3'b100
    } dsrf_size_t;

    typedef enum logic [2:0] {
        DSRF_SH_8B = 3'b000,
        DSRF_SH_16B = 3'b001,
        DSRF_SH_4H = 3'b010,
        DSRF_SH_8H = 3'b011,
        DSRF_SH_2S = 3'b100,
        DSRF_SH_4S = 3'b101,
        DSRF_SH_1D = 3'b110,
        DSRF_SH_2D = 3'b111
    } dsrf_shape_t;

endpackage

`default_nettype wire

//--- hw/dsrf_map_if.sv
// Architectural-to-physical register index lookup bundle
`default_nettype none

interface dsrf_map_if;
    logic exec_64;
    logic [4:0] mode;
    logic [4:0] arch_idx;
    logic [4:0] phys_idx;
    logic valid;

    modport req (output exec_64, output mode, output arch_idx, input phys_idx, input valid);
    modport map (input exec_64, input mode, input arch_idx, output phys_idx, output valid);
endinterface

`default_nettype wire

//--- hw/dsrf_bank_map.sv
// Banked register index translation for both execution states
`default_nettype none

module dsrf_bank_map
    import dsrf_pkg::*;
(
    dsrf_map_if.map m
);

    function automatic logic [4:0] bank_sp(input logic [4:0] mode);
        case (mode)
            DSRF_MODE_FIQ: bank_sp = DSRF_FIQ_SP;
            DSRF_MODE_IRQ: bank_sp = DSRF_IRQ_SP;
            DSRF_MODE_ABT: bank_sp = DSRF_ABT_SP;
            DSRF_MODE_SVC: bank_sp = DSRF_SVC_SP;
            DSRF_MODE_UND: bank_sp = DSRF_UND_SP;
            DSRF_MODE_HYP: bank_sp = DSRF_HYP_SP;
            default: bank_sp = 5'h0D;
        endcase
    endfunction

    function automatic logic [4:0] bank_lr(input logic [4:0] mode);
        case (mode)
            DSRF_MODE_FIQ: bank_lr = DSRF_FIQ_LR;
            DSRF_MODE_IRQ: bank_lr = DSRF_IRQ_LR;
            DSRF_MODE_ABT: bank_lr = DSRF_ABT_LR;
            DSRF_MODE_SVC: bank_lr = DSRF_SVC_LR;
            DSRF_MODE_UND: bank_lr = DSRF_UND_LR;
            default: bank_lr = 5'h0E;
        endcase
    endfunction

    always_comb
    begin
        m.phys_idx = m.arch_idx;
        m.valid = 1'b1;
        if (m.exec_64)
        begin
            // Index 31 is the zero register here
            m.valid = (m.arch_idx != DSRF_ZERO_IDX);
        end
        else if (m.arch_idx[4] || m.arch_idx == 5'h0F)
        begin
            // Program counter lives in the pipeline, not here
            m.valid = 1'b0;
        end
        else if (m.arch_idx == 5'h0D)
        begin
            m.phys_idx = bank_sp(m.mode);
        end
        else if (m.arch_idx == 5'h0E)
        begin
            m.phys_idx = bank_lr(m.mode);
        end
        else if (m.arch_idx[3] && m.mode == DSRF_MODE_FIQ)
        begin
            m.phys_idx = DSRF_FIQ_R8 + (m.arch_idx - 5'h08);
        end
    end

endmodule // dsrf_bank_map

`default_nettype wire

//--- hw/dsrf_lane.sv
// Vector lane extraction by shape qualifier
`default_nettype none

module dsrf_lane
    import dsrf_pkg::*;
(
    input wire logic [127:0] vec,
    input wire dsrf_shape_t shape,
    input wire logic [3:0] lane,
    output logic [63:0] elem
);

    always_comb
    begin
        elem = '0;
        case (shape)
            DSRF_SH_8B: if (!lane[3]) elem = {56'h0, vec[lane*8 +: 8]};
            DSRF_SH_16B: elem = {56'h0, vec[lane*8 +: 8]};
            DSRF_SH_4H: if (lane < 4'h4) elem = {48'h0, vec[lane[1:0]*16 +: 16]};
            DSRF_SH_8H: if (!lane[3]) elem = {48'h0, vec[lane[2:0]*16 +: 16]};
            DSRF_SH_2S: if (lane < 4'h2) elem = {32'h0, vec[lane[0]*32 +: 32]};
            DSRF_SH_4S: if (lane < 4'h4) elem = {32'h0, vec[lane[1:0]*32 +: 32]};
            DSRF_SH_1D: if (lane == 4'h0) elem = vec[63:0];
            DSRF_SH_2D: if (lane < 4'h2) elem = vec[lane[0]*64 +: 64];
            default: elem = '0;
        endcase
    end

endmodule // dsrf_lane

`default_nettype wire

//--- sim/dsrf_exc_model.sv
// Exception entry stand-in for the pipeline side
`default_nettype none
module dsrf_exc_model
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [1:0] tgt,
    input wire logic [63:0] ra,
    output logic exc_take,
    output logic [1:0] exc_target,
    output logic [63:0] exc_ret_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle lines flip so a stale address never looks valid
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            exc_take <= 1'b0;
            exc_target <= 2'h0;
            exc_ret_addr <= 64'h0;
        end
        else
        begin
            exc_take <= go;
            exc_target <= go ? tgt : ~exc_target;
            exc_ret_addr <= go ? ra : ~exc_ret_addr;
        end
    end
endmodule // dsrf_exc_model
`default_nettype wire

//--- sim/dsrf_top_test.sv
// Self-checking bench for the dual-state register file
`default_nettype none
module dsrf_top_test
    import dsrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst_b = 1'b0, exec_64 = 1'b1, fsi = 1'b1, den, xt;
    logic [1:0] lvl = 2'h2, xtg = 2'h0, xg;
    logic [7:0] stb = 8'h00, sa = 8'h00;
    logic [4:0] gri = 5'h00, gwi = 5'h00, fri = 5'h00, fwi = 5'h00;
    logic [3:0] fln = 4'h0;
    logic [31:0] swd = 32'h0, srd, ps;
    logic [63:0] gwd = 64'h0, xra = 64'h0, grd, flane, xa;
    logic [127:0] fwd = 128'h0, frd;
    dsrf_size_t frs = DSRF_SZ_Q, fws = DSRF_SZ_Q;
    dsrf_shape_t fsh = DSRF_SH_2D;
    int error_cnt = 0, checks = 0;
    logic [4:0] md [6] = '{DSRF_MODE_FIQ, DSRF_MODE_IRQ, DSRF_MODE_ABT, DSRF_MODE_UND,
        DSRF_MODE_HYP, DSRF_MODE_SVC};
    logic [4:0] sp [6] = '{DSRF_FIQ_SP, DSRF_IRQ_SP, DSRF_ABT_SP, DSRF_UND_SP,
        DSRF_HYP_SP, DSRF_SVC_SP};
    // Lane 1 per shape; the single-lane shape has no lane 1
    logic [63:0] ln1 [8] = '{64'h01, 64'h01, 64'h0302, 64'h0302, 64'h07060504,
        64'h07060504, 64'h0, 64'h0F0E0D0C0B0A0908};

    always #2.5 mclk = ~mclk;

    dsrf_exc_model dsrf_exc_model_inst (.mclk(mclk), .rst_b(rst_b), .go(stb[6]), .tgt(xtg),
        .ra(xra), .exc_take(xt), .exc_target(xg), .exc_ret_addr(xa));
    dsrf_top dsrf_top_inst (.mclk(mclk), .rst_b(rst_b), .exec_64(exec_64), .cur_level(lvl),
        .sat_event(stb[7]), .gpr_rd_en(stb[0]), .gpr_rd_idx(gri), .gpr_rd_data(grd),
        .gpr_wr_en(stb[1]), .gpr_wr_idx(gwi), .gpr_wr_data(gwd), .fp_rd_en(stb[2]),
        .fp_rd_idx(fri), .fp_rd_size(frs), .fp_rd_simd(fsi), .fp_rd_shape(fsh),
        .fp_rd_lane(fln), .fp_rd_data(frd), .fp_lane_data(flane), .fp_wr_en(stb[3]),
        .fp_wr_idx(fwi), .fp_wr_size(fws), .fp_wr_simd(fsi), .fp_wr_data(fwd),
        .sys_addr(sa), .sys_wdata(swd), .sys_wr(stb[5]), .sys_rd(stb[4]), .sys_rdata(srd),
        .sys_denied(den), .exc_take(xt), .exc_target(xg), .exc_ret_addr(xa),
        .processor_state(ps));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Fields settle a cycle ahead of the strobe; answers are taken one edge later
    task automatic pulse(input int b);
        @(posedge mclk);
        stb[b] <= 1'b1;
        @(posedge mclk);
        stb[b] <= 1'b0;
        #1;
    endtask
    task automatic gw(input logic [4:0] i, input logic [63:0] d);
        gwi <= i;
        gwd <= d;
        pulse(1);
    endtask
    task automatic gr(input logic [4:0] i, input logic [63:0] e);
        gri <= i;
        pulse(0);
        chk(128'(grd), 128'(e));
    endtask
    task automatic sw(input logic [7:0] a, input logic [31:0] d);
        sa <= a;
        swd <= d;
        pulse(5);
    endtask
    task automatic sr(input logic [7:0] a, input logic [32:0] e);
        sa <= a;
        pulse(4);
        chk(128'({den, srd}), 128'(e));
    endtask
    task automatic fw(input logic [4:0] i, input dsrf_size_t s, input logic [127:0] d);
        fwi <= i;
        fws <= s;
        fwd <= d;
        pulse(3);
    endtask
    task automatic fr(input logic [4:0] i, input dsrf_size_t s, input logic m,
        input dsrf_shape_t h, input logic [3:0] l);
        fri <= i;
        frs <= s;
        fsi <= m;
        fsh <= h;
        fln <= l;
        pulse(2);
    endtask
    task automatic final_report;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        chk(128'(ps), 128'(DSRF_CUR_RST));
        gw(5'h1E, 64'hA5A5_0123_4567_89AB);
        gr(5'h1E, 64'hA5A5_0123_4567_89AB);
        gw(5'h1F, 64'h1);
        gr(5'h1F, 64'h0);
        // Write then read with no gap between the strobes
        gwi <= 5'h05;
        gwd <= 64'h0123_4567_89AB_CDEF;
        gri <= 5'h05;
        @(posedge mclk);
        stb <= 8'h02;
        @(posedge mclk);
        stb <= 8'h01;
        @(posedge mclk);
        stb <= 8'h00;
        #1;
        chk(128'(grd), 128'h0123_4567_89AB_CDEF);
        gw(DSRF_SVC_SP, 64'hCAFE_F00D_0000_0000);
        exec_64 <= 1'b0;
        foreach (md[k])
        begin
            sw(DSRF_OFS_CUR, {27'h00E, md[k]});
            gw(5'h0D, 64'({27'h5A, md[k]}));
            gr(5'h0D, 64'({27'h5A, md[k]}));
            gw(5'h08, 64'({27'h3C, md[k]}));
            sw(DSRF_OFS_SPS_FIQ, {27'h71, md[k]});
        end
        gr(5'h0D, 64'({27'h5A, DSRF_MODE_SVC}));
        gr(5'h0F, 64'h0);
        exec_64 <= 1'b1;
        foreach (sp[k])
            gr(sp[k], {(k == 5) ? 32'hCAFE_F00D : 32'h0, 27'h5A, md[k]});
        gr(DSRF_FIQ_R8, 64'({27'h3C, DSRF_MODE_FIQ}));
        gr(5'h08, 64'({27'h3C, DSRF_MODE_SVC}));
        gr(5'h1E, 64'hA5A5_0123_4567_89AB);
        lvl <= 2'h1;
        sw(DSRF_OFS_SPS_OS, 32'h6000_01D3);
        sr(DSRF_OFS_SPS_OS, 33'h0_6000_01D3);
        sr(DSRF_OFS_SPS_FIQ, 33'h1_0000_0000);
        lvl <= 2'h2;
        sr(DSRF_OFS_SPS_FIQ, 33'({27'h71, DSRF_MODE_SVC}));
        sr(8'hFC, 33'h0);
        // Exception from the compatibility state in user mode
        exec_64 <= 1'b0;
        sw(DSRF_OFS_CUR, 32'h0000_01D0);
        sr(DSRF_OFS_CUR, 33'h1_0000_0000);
        xtg <= 2'h1;
        xra <= 64'hFFFF_FFFF_1234_5678;
        pulse(6);
        repeat (2) @(posedge mclk);
        exec_64 <= 1'b1;
        sr(DSRF_OFS_ELR1_HI, 33'h0);
        sr(DSRF_OFS_ELR1_LO, 33'h0_1234_5678);
        sr(DSRF_OFS_SPS_OS, 33'h0_0000_01D0);
        pulse(7);
        chk(128'(ps[DSRF_CUR_Q]), 128'h1);
        fw(5'h02, DSRF_SZ_S, {128{1'b1}});
        fr(5'h02, DSRF_SZ_Q, 1'b1, DSRF_SH_4S, 4'h0);
        chk(frd, 128'hFFFF_FFFF);
        fr(5'h02, DSRF_SZ_H, 1'b1, DSRF_SH_4S, 4'h0);
        chk(frd, 128'hFFFF);
        fr(5'h02, DSRF_SZ_B, 1'b0, DSRF_SH_4S, 4'h0);
        chk(frd, 128'h0);
        fw(5'h02, DSRF_SZ_B, 128'h0);
        fr(5'h02, DSRF_SZ_H, 1'b1, DSRF_SH_4S, 4'h0);
        chk(frd, 128'hFFFF);
        fw(5'h14, DSRF_SZ_Q, 128'h0F0E0D0C_0B0A0908_07060504_03020100);
        fr(5'h14, DSRF_SZ_S, 1'b1, DSRF_SH_4S, 4'h0);
        chk(frd, 128'h0302_0100);
        for (int s = 0; s < 8; s++)
        begin
            fr(5'h14, DSRF_SZ_Q, 1'b1, dsrf_shape_t'(s), 4'h1);
            chk(128'(flane), 128'(ln1[s]));
        end
        exec_64 <= 1'b0;
        fw(5'h14, DSRF_SZ_Q, 128'h0);
        fw(5'h03, DSRF_SZ_D, {128{1'b1}});
        fr(5'h14, DSRF_SZ_Q, 1'b1, DSRF_SH_2D, 4'h0);
        chk(frd, 128'h0);
        exec_64 <= 1'b1;
        fr(5'h14, DSRF_SZ_Q, 1'b1, DSRF_SH_2D, 4'h0);
        chk(frd, 128'h0F0E0D0C_0B0A0908_07060504_03020100);
        fr(5'h03, DSRF_SZ_Q, 1'b1, DSRF_SH_2D, 4'h0);
        chk(frd, 128'hFFFF_FFFF_FFFF_FFFF);
        final_report();
    end
endmodule // dsrf_top_test
`default_nettype wire
